/* verilog/eeewe_pkg.sv */
// constants for the port eee advertisement and wake error block
package eeewe_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_ADV = 10'h0e0;
    localparam logic [9:0] IDX_WEC = 10'h0e2;
    localparam logic [9:0] IDX_STAT = 10'h0f0;
    localparam logic [9:0] IDX_IRQ_STS = 10'h0f8;
    localparam logic [9:0] IDX_IRQ_EN = 10'h0f9;
    localparam logic [9:0] IDX_IRQ_CLR = 10'h0fa;
    // advertisement register fields
    localparam int unsigned LP_LSB = 9;
    localparam int unsigned LP_MSB = 14;
    localparam int unsigned LP_W = 6;
    localparam int unsigned ADV_TX_BIT = 1;
    localparam int unsigned ADV_RO_LSB = 2;
    localparam int unsigned ADV_RO_MSB = 6;
    localparam logic ADV_TX_RST = 1'b1;
    // wake error counter
    localparam int unsigned WEC_W = 16;
    localparam logic [15:0] WEC_RST = 16'h0000;
    // interrupt status bits
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_WAKE = 0;
    localparam int unsigned IRQ_LPUPD = 1;
    localparam int unsigned IRQ_SAT = 2;
    localparam logic [2:0] IRQ_RST = 3'h0;
    // block status register bits
    localparam int unsigned ST_COPPER = 0;
    localparam int unsigned ST_LPVAL = 1;
    localparam int unsigned ST_WAKE = 2;
    localparam int unsigned ST_TMR = 3;
    // wake time limit
    localparam int unsigned CLK_MHZ = 40;
    localparam real WAKE_TIME_US = 20.5;
    localparam int unsigned WAKE_CYC = int'($ceil(WAKE_TIME_US * CLK_MHZ));
    localparam int unsigned WAKE_CW = $clog2(WAKE_CYC + 1);
endpackage : eeewe_pkg

/* verilog/eeewe_wake_timer.sv */
// wake duration timer, flags a wake-up that lasts as long as the limit
`timescale 1ns/1ps
module eeewe_wake_timer import eeewe_pkg::*; #(
    parameter int unsigned CYC = WAKE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wake_i,
    output logic done_o
);
    localparam int unsigned CW = $clog2(CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(CYC - 1);

    logic [CW-1:0] cnt_q;
    logic done_q;

    always_ff @(posedge clk_i) begin
        if (rst_i || !wake_i) begin
            cnt_q <= '0;
        end else if (cnt_q != CW'(CYC)) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // done holds until the wake ends
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_q <= 1'b0;
        end else begin
            done_q <= wake_i && (cnt_q == LAST || done_q);
        end
    end

    assign done_o = done_q;

    done_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !wake_i |=> !done_q)
        else $error("wake timer done outlived the wake");
endmodule : eeewe_wake_timer

/* verilog/eeewe_sat_cnt.sv */
// saturating event counter with clear that keeps a coincident event
`timescale 1ns/1ps
module eeewe_sat_cnt import eeewe_pkg::*; #(
    parameter int unsigned W = WEC_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic inc_i,
    input wire logic clr_i,
    output logic [W-1:0] cnt_o,
    output logic sat_o
);
    logic [W-1:0] cnt_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= W'(WEC_RST);
        end else if (clr_i) begin
            cnt_q <= {{(W-1){1'b0}}, inc_i};
        end else if (inc_i && !(&cnt_q)) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign cnt_o = cnt_q;
    assign sat_o = &cnt_q;

    sat_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (&cnt_q) && !clr_i |=> (&cnt_q))
        else $error("saturated counter moved without a clear");
endmodule : eeewe_sat_cnt

/* verilog/eeewe_regs.sv */
// eee advertisement, link partner flags and wake error counter, wishbone slave
`timescale 1ns/1ps
module eeewe_regs import eeewe_pkg::*; #(
    parameter int unsigned WAKE_LIMIT = WAKE_CYC,
    parameter int unsigned WEC_WIDTH = WEC_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic fiber_mode_i,
    input wire logic link_down_i,
    input wire logic np_eee_valid_i,
    input wire logic [5:0] np_eee_adv_i,
    input wire logic lpi_wake_i,
    output logic eee_adv_100tx_o,
    output logic irq_o
);
    logic req;
    logic rd;
    logic wr;
    logic [9:0] idx;
    logic hit_adv;
    logic hit_wec;
    logic hit_stat;
    logic hit_sts;
    logic hit_en;
    logic hit_clr;
    logic copper;
    logic wake_act;
    logic tmr_done;
    logic tmr_done_q;
    logic wake_err;
    logic wec_clr;
    logic [WEC_WIDTH-1:0] wec_cnt;
    logic wec_sat;
    logic adv_tx_q;
    logic [LP_W-1:0] lp_q;
    logic lp_val_q;
    logic lp_upd;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr_mask;
    logic [IRQ_W-1:0] sts_q;
    logic [IRQ_W-1:0] en_q;
    logic [31:0] rdata;
    logic [31:0] dat_q;
    logic ack_q;
    logic adv_o_q;
    logic irq_q;
    logic [WAKE_CW-1:0] wake_len_q;

    // bus decode, one request per ack
    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign rd = req && !wb_we_i;
    assign wr = req && wb_we_i;
    assign idx = wb_adr_i[11:2];
    assign hit_adv = (idx == IDX_ADV);
    assign hit_wec = (idx == IDX_WEC);
    assign hit_stat = (idx == IDX_STAT);
    assign hit_sts = (idx == IDX_IRQ_STS);
    assign hit_en = (idx == IDX_IRQ_EN);
    assign hit_clr = (idx == IDX_IRQ_CLR);

    // eee only runs on copper
    assign copper = !fiber_mode_i;
    assign wake_act = lpi_wake_i && copper;

    // local 100base-tx advertisement
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            adv_tx_q <= ADV_TX_RST;
        end else if (wr && hit_adv && wb_sel_i[0]) begin
            adv_tx_q <= wb_dat_i[ADV_TX_BIT];
        end
    end

    // link partner flags from the next-page exchange
    assign lp_upd = np_eee_valid_i && copper && !link_down_i;

    always_ff @(posedge clk_i) begin
        if (rst_i || link_down_i || !copper) begin
            lp_q <= '0;
            lp_val_q <= 1'b0;
        end else if (np_eee_valid_i) begin
            lp_q <= np_eee_adv_i;
            lp_val_q <= 1'b1;
        end
    end

    // wake duration watchdog
    eeewe_wake_timer #(
        .CYC(WAKE_LIMIT)
    ) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wake_i(wake_act),
        .done_o(tmr_done)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tmr_done_q <= 1'b0;
        end else begin
            tmr_done_q <= tmr_done;
        end
    end

    // false to true of the timer done
    assign wake_err = tmr_done && !tmr_done_q;
    assign wec_clr = rd && hit_wec;

    eeewe_sat_cnt #(
        .W(WEC_WIDTH)
    ) u_wec (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .inc_i(wake_err),
        .clr_i(wec_clr),
        .cnt_o(wec_cnt),
        .sat_o(wec_sat)
    );

    // interrupt events
    assign ev[IRQ_WAKE] = wake_err;
    assign ev[IRQ_LPUPD] = lp_upd;
    assign ev[IRQ_SAT] = wake_err && wec_sat && !wec_clr;

    assign clr_mask = (wr && hit_clr && wb_sel_i[0]) ? wb_dat_i[IRQ_W-1:0] : '0;

    // set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sts_q <= IRQ_RST;
        end else begin
            sts_q <= (sts_q & ~clr_mask) | ev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_q <= IRQ_RST;
        end else if (wr && hit_en && wb_sel_i[0]) begin
            en_q <= wb_dat_i[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(sts_q & en_q);
        end
    end

    // read mux; reserved and unmapped read zero
    always_comb begin
        rdata = '0;
        case (idx)
            IDX_ADV: begin
                rdata[LP_MSB:LP_LSB] = lp_q;
                rdata[ADV_TX_BIT] = adv_tx_q;
            end
            IDX_WEC: begin
                rdata[WEC_WIDTH-1:0] = wec_cnt;
            end
            IDX_STAT: begin
                rdata[ST_COPPER] = copper;
                rdata[ST_LPVAL] = lp_val_q;
                rdata[ST_WAKE] = wake_act;
                rdata[ST_TMR] = tmr_done;
            end
            IDX_IRQ_STS: begin
                rdata[IRQ_W-1:0] = sts_q;
            end
            IDX_IRQ_EN: begin
                rdata[IRQ_W-1:0] = en_q;
            end
            default: begin
                rdata = '0;
            end
        endcase
    end

    // ack one cycle after the request, dropped the next
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= '0;
        end else if (rd) begin
            dat_q <= rdata;
        end
    end

    // advertisement seen by auto-negotiation
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            adv_o_q <= 1'b0;
        end else begin
            adv_o_q <= adv_tx_q && copper;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign eee_adv_100tx_o = adv_o_q;
    assign irq_o = irq_q;

    // helper: length of the current wake
    always_ff @(posedge clk_i) begin
        if (rst_i || !wake_act) begin
            wake_len_q <= '0;
        end else if (wake_len_q != '1) begin
            wake_len_q <= wake_len_q + 1'b1;
        end
    end

    lp_capture_a: assert property (@(posedge clk_i) disable iff (rst_i)
        lp_upd |=> lp_q == $past(np_eee_adv_i))
        else $error("partner flags not taken from the next page");

    lp_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        link_down_i |=> lp_q == '0 && !lp_val_q)
        else $error("partner flags survived link down");

    lp_stable_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !np_eee_valid_i && !link_down_i && copper |=> $stable(lp_q))
        else $error("partner flags changed without an exchange");

    adv_reset_a: assert property (@(posedge clk_i)
        rst_i |=> adv_tx_q)
        else $error("100base-tx advert not one after reset");

    adv_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && hit_adv && wb_sel_i[0] |=> adv_tx_q == $past(wb_dat_i[ADV_TX_BIT]))
        else $error("100base-tx advert write lost");

    adv_ro_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd && hit_adv |=> wb_ack_o && wb_dat_o[ADV_RO_MSB:ADV_RO_LSB] == '0)
        else $error("read-only advert bits not zero");

    fiber_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fiber_mode_i |=> !eee_adv_100tx_o && lp_q == '0 && !ev[IRQ_WAKE])
        else $error("eee active in fiber mode");

    wake_inc_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wake_err && !wec_clr && !wec_sat |=> wec_cnt == $past(wec_cnt) + 1'b1)
        else $error("wake error not counted");

    wake_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(tmr_done) |-> wake_len_q == WAKE_CW'(WAKE_LIMIT))
        else $error("wake error flagged at wrong wake length");

    no_spur_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !wake_err && !wec_clr |=> $stable(wec_cnt))
        else $error("counter moved without an event");

    rc_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wec_clr && !wake_err |=> wec_cnt == '0 && wb_dat_o[WEC_WIDTH-1:0] == $past(wec_cnt))
        else $error("counter read did not return then clear");

    sat_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wake_err && wec_sat && !wec_clr |=> sts_q[IRQ_SAT] && wec_sat)
        else $error("overflow not held at all ones");

    irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 irq_o == |($past(sts_q) & $past(en_q)))
        else $error("interrupt output does not follow enabled status");

    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("bus ack held longer than one cycle");

    ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req |=> wb_ack_o)
        else $error("bus request not acknowledged next cycle");

    lp_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd && hit_adv |=> wb_dat_o[LP_MSB:LP_LSB] == $past(lp_q))
        else $error("partner flags not returned on read");

    lp_valid_a: assert property (@(posedge clk_i) disable iff (rst_i)
        lp_upd |=> lp_val_q)
        else $error("partner flags not marked valid after exchange");

    adv_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd && hit_adv |=> wb_dat_o[ADV_TX_BIT] == $past(adv_tx_q))
        else $error("100base-tx advert not returned on read");

    adv_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd && hit_adv |=> wb_dat_o[31:LP_MSB+1] == '0
            && wb_dat_o[LP_LSB-1:ADV_RO_MSB+1] == '0 && !wb_dat_o[ADV_TX_BIT-1])
        else $error("reserved advert bits not zero");

    adv_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !adv_tx_q |=> !eee_adv_100tx_o)
        else $error("advert output high with the advert bit clear");

    fiber_timer_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fiber_mode_i |=> !tmr_done)
        else $error("wake timer ran in fiber mode");

    sat_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wec_sat && rd && hit_wec |=> &wb_dat_o[WEC_WIDTH-1:0])
        else $error("saturated count not read as all ones");

    wake_sts_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wake_err |=> sts_q[IRQ_WAKE])
        else $error("wake error did not set its status bit");

    sts_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr && hit_clr) |=> (sts_q & $past(sts_q)) == $past(sts_q))
        else $error("status bit dropped without a clear");

    sts_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && hit_clr && wb_sel_i[0]
            |=> (sts_q & $past(wb_dat_i[IRQ_W-1:0]) & ~$past(ev)) == '0)
        else $error("status bit survived its clear");

    en_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && hit_en && wb_sel_i[0] |=> en_q == $past(wb_dat_i[IRQ_W-1:0]))
        else $error("interrupt enable write lost");
endmodule : eeewe_regs

/* dv/eeewe_phy_model.sv */
// link partner model: next-page eee advert pulses and lpi wake levels
`timescale 1ns/1ps
module eeewe_phy_model (
    input wire logic clk_i,
    output logic np_eee_valid_o,
    output logic [5:0] np_eee_adv_o,
    output logic lpi_wake_o
);
    initial begin
        np_eee_valid_o = 1'b0;
        np_eee_adv_o = 6'h15;
        lpi_wake_o = 1'b0;
    end
    // advert bits mean nothing outside the valid cycle, so scramble them
    task automatic send_adv(input logic [5:0] bits);
        @(posedge clk_i);
        np_eee_valid_o <= 1'b1;
        np_eee_adv_o <= bits;
        @(posedge clk_i);
        np_eee_valid_o <= 1'b0;
        np_eee_adv_o <= ~bits;
    endtask : send_adv
    // wake held high for cyc edges, then idle so the count settles
    task automatic wake(input int unsigned cyc);
        @(posedge clk_i);
        lpi_wake_o <= 1'b1;
        repeat (cyc) @(posedge clk_i);
        lpi_wake_o <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask : wake
endmodule : eeewe_phy_model

/* dv/eee_advert_wake_error_regs_bench.sv */
// self-checking bench for the eee advertisement and wake error registers
`timescale 1ns/1ps
module eee_advert_wake_error_regs_bench import eeewe_pkg::*;;
    localparam int unsigned LIM = 8;
    // narrow wake error counter so saturation is reached quickly
    localparam int unsigned WEC_T = 4;
    logic clk = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h0000_0000;
    logic [3:0] sel = 4'hf, wsel = 4'hf;
    logic fiber = 1'b0, link_down = 1'b0;
    logic [31:0] rdat;
    logic ack, adv_tx, irq, np_valid, wake;
    logic [5:0] np_adv;
    logic [31:0] exp_q[$];
    logic [31:0] seed = 32'h0000_ce28;
    logic [5:0] lp;
    int errors = 0;
    int n_tests = 0;

    always #12.5 clk = ~clk;

    eeewe_regs #(.WAKE_LIMIT(LIM), .WEC_WIDTH(WEC_T)) u_eeewe_regs (
        .clk_i(clk), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .fiber_mode_i(fiber), .link_down_i(link_down),
        .np_eee_valid_i(np_valid), .np_eee_adv_i(np_adv), .lpi_wake_i(wake),
        .eee_adv_100tx_o(adv_tx), .irq_o(irq));

    eeewe_phy_model u_eeewe_phy_model (
        .clk_i(clk), .np_eee_valid_o(np_valid), .np_eee_adv_o(np_adv),
        .lpi_wake_o(wake));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : compare

    // read results leave through the queue, checked when ack shows
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (exp_q.size() == 0) begin
                compare(rdat, 32'hdead_beef);
            end else begin
                compare(rdat, exp_q.pop_front());
            end
        end
    end

    task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= wsel;
        adr <= {idx, 2'b00};
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : bus

    task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
        exp_q.push_back(exp);
        bus(1'b0, idx, 32'h0000_0000);
    endtask : rd

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        final_report();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk);
        rd(IDX_ADV, 32'h0000_0002);
        rd(IDX_WEC, 32'h0000_0000);
        rd(IDX_STAT, 32'h0000_0001);
        compare({31'h0, adv_tx}, 32'h1);
        bus(1'b1, IDX_ADV, 32'hffff_fffd);
        rd(IDX_ADV, 32'h0000_0000);
        repeat (2) @(posedge clk);
        compare({31'h0, adv_tx}, 32'h0);
        u_eeewe_phy_model.send_adv(6'h01); // advert off alone keeps eee negotiating
        rd(IDX_ADV, 32'h0000_0200);
        bus(1'b1, IDX_ADV, 32'hffff_ffff);
        rd(IDX_ADV, 32'h0000_0202);
        wsel = 4'he;
        bus(1'b1, IDX_ADV, 32'h0000_0000);
        wsel = 4'hf;
        rd(IDX_ADV, 32'h0000_0202);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            lp = seed[5:0];
            u_eeewe_phy_model.send_adv(lp);
            rd(IDX_ADV, {16'h0, 1'b0, lp, 9'h002});
        end
        link_down <= 1'b1;
        rd(IDX_ADV, 32'h0000_0002);
        link_down <= 1'b0;
        bus(1'b1, IDX_IRQ_EN, 32'h0000_0001);
        rd(IDX_IRQ_EN, 32'h0000_0001);
        u_eeewe_phy_model.wake(LIM - 2);
        rd(IDX_WEC, 32'h0000_0000);
        compare({31'h0, irq}, 32'h0);
        u_eeewe_phy_model.wake(LIM + 3);
        u_eeewe_phy_model.wake(LIM + 3);
        compare({31'h0, irq}, 32'h1);
        rd(IDX_IRQ_STS, 32'h0000_0003);
        rd(IDX_WEC, 32'h0000_0002);
        rd(IDX_WEC, 32'h0000_0000);
        bus(1'b1, IDX_IRQ_CLR, 32'h0000_0007);
        repeat (2) @(posedge clk);
        compare({31'h0, irq}, 32'h0);
        rd(IDX_IRQ_STS, 32'h0000_0000);
        for (int i = 0; i < (1 << WEC_T); i++) begin
            u_eeewe_phy_model.wake(LIM + 3);
        end
        rd(IDX_WEC, (32'h0000_0001 << WEC_T) - 32'h0000_0001);
        rd(IDX_IRQ_STS, 32'h0000_0005);
        rd(IDX_WEC, 32'h0000_0000);
        rd(10'h1ff, 32'h0000_0000);
        fiber <= 1'b1;
        u_eeewe_phy_model.send_adv(6'h3f);
        u_eeewe_phy_model.wake(LIM + 3);
        rd(IDX_ADV, 32'h0000_0002);
        rd(IDX_WEC, 32'h0000_0000);
        rd(IDX_STAT, 32'h0000_0000);
        compare({31'h0, adv_tx}, 32'h0);
        fiber <= 1'b0;
        repeat (4) @(posedge clk);
        if (exp_q.size() != 0) begin
            errors++;
        end
        final_report();
    end
endmodule : eee_advert_wake_error_regs_bench
